//--- rtl/msr_pkg.sv
// package: constants for the scaled-parameter request responder
package msr_pkg;

  // ==========================================================================
  // function codes and exception marking
  localparam logic [7:0] FUNC_READ = 8'h03;
  localparam logic [7:0] FUNC_WRITE = 8'h06;
  localparam logic [7:0] EXC_FLAG = 8'h80;

  // ==========================================================================
  // exception codes
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
  localparam logic [7:0] EXC_BAD_DATA = 8'h03;
  localparam logic [7:0] EXC_OP_FAIL = 8'h04;
  localparam logic [7:0] EXC_PASSWORD = 8'h05;
  localparam logic [7:0] EXC_FRAME = 8'h06;
  localparam logic [7:0] EXC_READ_ONLY = 8'h07;
  localparam logic [7:0] EXC_RUN_LOCKED = 8'h08;
  localparam logic [7:0] EXC_SYS_LOCKED = 8'h09;

  // ==========================================================================
  // password verification register address
  localparam logic [15:0] PASSWORD_ADDR = 16'h0FFF;
  localparam logic [15:0] PASSWORD_NONE = 16'h0000;

  // ==========================================================================
  // crc-16 of the serial link
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  // ==========================================================================
  // power-of-ten scales indexed by decimal places
  localparam int SCALE_MAX_DEC = 3;
  localparam logic [15:0] SCALE_1 = 16'h0001;
  localparam logic [15:0] SCALE_10 = 16'h000A;
  localparam logic [15:0] SCALE_100 = 16'h0064;
  localparam logic [15:0] SCALE_1000 = 16'h03E8;

  // ==========================================================================
  // responder states, gray along idle -> send
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } msr_state_t;

endpackage

//--- rtl/msr_responder.sv
// module: checks parameter requests and builds normal or exception replies
//
// Overview of operation
// [R1] bus scale is ten to decimal places
// [R2] master sends decimal value times scale
// [R3] write stores received integer divided by scale
// [R4] read returns scaled integer; master divides
// [R5] 01H for unknown function or faulted drive
// [R6] 02H for illegal address and length
// [R7] 03H for structurally illegal data field
// [R8] 04H for out-of-range or conflicting value
// [R9] 05H when verified password mismatches
// [R10] 06H for bad length or CRC
// [R11] 07H when writing read-only parameter
// [R12] 08H when writing run-locked while running
// [R13] 09H for any access while locked; the code still lets a write to PASSWORD_ADDR through
// [R14] normal reply echoes function and address
// [R15] exception reply sets function code MSB
// [R16] exception reply carries one code byte
// [R17] master retries or fixes on exception
// [R18] RTU exception reply appends CRC
`timescale 1ns/10ps
`default_nettype none
module msr_responder
  import msr_pkg::*;
#(
  parameter int MAX_READ_WORDS = 16
)
(
  input wire logic MCLK,
  input wire logic RST_N,
  // request from the frame parser
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic [7:0] REQ_FUNC,
  input wire logic [15:0] REQ_ADDR,
  input wire logic [15:0] REQ_DATA,
  input wire logic REQ_LEN_OK,
  input wire logic REQ_CRC_OK,
  input wire logic RTU_MODE,
  input wire logic [7:0] SLAVE_ADDR,
  // drive and parameter context for the addressed parameter
  input wire logic DRIVE_RUNNING,
  input wire logic DRIVE_FAULT,
  input wire logic ADDR_SPAN_OK,
  input wire logic PARAM_READ_ONLY,
  input wire logic PARAM_RUN_LOCKED,
  input wire logic PARAM_CONFLICT,
  input wire logic [1:0] PARAM_DECIMALS,
  input wire logic [15:0] PARAM_MIN,
  input wire logic [15:0] PARAM_MAX,
  input wire logic [15:0] PARAM_RD_WHOLE,
  input wire logic [9:0] PARAM_RD_FRAC,
  input wire logic [15:0] USER_PASSWORD_SETTING,
  // response toward the frame builder
  output logic RSP_VALID,
  output logic RSP_EXC,
  output logic [7:0] RSP_FUNC,
  output logic [15:0] RSP_ADDR,
  output logic [15:0] RSP_DATA,
  output logic [7:0] RSP_EXC_CODE,
  output logic RSP_CRC_EN,
  output logic [15:0] RSP_CRC,
  // parameter store update
  output logic PARAM_WR,
  output logic [15:0] PARAM_WR_ADDR,
  output logic [15:0] PARAM_WR_WHOLE,
  output logic [9:0] PARAM_WR_FRAC,
  output logic SYS_UNLOCKED
);

  // ==========================================================================
  // elaboration checks
  if (MAX_READ_WORDS < 1 || MAX_READ_WORDS > 125)
  begin : g_bad_max_read
    $error("MAX_READ_WORDS must lie between 1 and 125");
  end

  localparam logic [15:0] MAX_READ = 16'(MAX_READ_WORDS);

  // ==========================================================================
  // helpers

  // crc-16 over slave address, marked function code and exception byte
  function automatic logic [15:0] exc_crc(input logic [23:0] bytes3);
    logic [15:0] c;
    logic [7:0] b;
    c = CRC_INIT;
    for (int i = 0; i < 3; i++)
    begin
      b = bytes3[23 - 8 * i -: 8];
      c = c ^ {8'h00, b};
      for (int j = 0; j < 8; j++)
      begin
        c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
    end
    return c;
  endfunction

  // scale from decimal places; table keeps the divider to constants
  function automatic logic [15:0] dec_scale(input logic [1:0] dec);
    logic [15:0] s;
    case (dec)
      2'h0: s = SCALE_1;
      2'h1: s = SCALE_10;
      2'h2: s = SCALE_100;
      default: s = SCALE_1000;
    endcase
    return s;
  endfunction

  // ==========================================================================
  // state
  msr_state_t state, next_state;
  logic unlocked, next_unlocked;
  logic rsp_exc, next_rsp_exc;
  logic [7:0] rsp_func, next_rsp_func;
  logic [15:0] rsp_addr, next_rsp_addr;
  logic [15:0] rsp_data, next_rsp_data;
  logic [7:0] rsp_code, next_rsp_code;
  logic rsp_crc_en, next_rsp_crc_en;
  logic [15:0] rsp_crc, next_rsp_crc;
  logic wr_go, next_wr_go;
  logic [15:0] wr_addr, next_wr_addr;
  logic [15:0] wr_whole, next_wr_whole;
  logic [9:0] wr_frac, next_wr_frac;

  // decode terms for the request being offered
  logic [15:0] scale;
  logic is_read, is_write, is_pw_addr, pw_set, take;
  logic [7:0] code;
  logic [31:0] rd_scaled;

  assign scale = dec_scale(PARAM_DECIMALS); // R1
  assign is_read = (REQ_FUNC == FUNC_READ);
  assign is_write = (REQ_FUNC == FUNC_WRITE);
  assign is_pw_addr = (REQ_ADDR == PASSWORD_ADDR);
  assign pw_set = (USER_PASSWORD_SETTING != PASSWORD_NONE);
  assign take = REQ_VALID && (state == ST_IDLE);
  // read data leaves scaled; wrap to the 16-bit register width
  assign rd_scaled = {16'h0000, PARAM_RD_WHOLE} * {16'h0000, scale}
                   + {22'h0, PARAM_RD_FRAC}; // R4

  // ==========================================================================
  // exception priority: frame, function, lock, password, address, data, then write checks
  always_comb
  begin
    code = EXC_NONE;
    if (!REQ_LEN_OK || (RTU_MODE && !REQ_CRC_OK))
      code = EXC_FRAME; // R10
    else if ((!is_read && !is_write) || DRIVE_FAULT)
      code = EXC_ILLEGAL_FUNC; // R5
    else if (pw_set && !unlocked && !(is_write && is_pw_addr))
      code = EXC_SYS_LOCKED; // R13
    else if (is_write && is_pw_addr)
      code = (REQ_DATA == USER_PASSWORD_SETTING) ? EXC_NONE : EXC_PASSWORD; // R9
    else if (!ADDR_SPAN_OK)
      code = EXC_BAD_ADDR; // R6
    else if (is_read && (REQ_DATA == 16'h0000 || REQ_DATA > MAX_READ))
      code = EXC_BAD_DATA; // R7
    else if (is_write && PARAM_READ_ONLY)
      code = EXC_READ_ONLY; // R11
    else if (is_write && PARAM_RUN_LOCKED && DRIVE_RUNNING)
      code = EXC_RUN_LOCKED; // R12
    else if (is_write && (REQ_DATA < PARAM_MIN || REQ_DATA > PARAM_MAX || PARAM_CONFLICT))
      code = EXC_OP_FAIL; // R8
  end

  // ==========================================================================
  // next values: one request taken per idle cycle, reply held for one send cycle
  always_comb
  begin
    next_state = state;
    next_unlocked = unlocked;
    next_rsp_exc = rsp_exc;
    next_rsp_func = rsp_func;
    next_rsp_addr = rsp_addr;
    next_rsp_data = rsp_data;
    next_rsp_code = rsp_code;
    next_rsp_crc_en = rsp_crc_en;
    next_rsp_crc = rsp_crc;
    next_wr_go = 1'b0;
    next_wr_addr = wr_addr;
    next_wr_whole = wr_whole;
    next_wr_frac = wr_frac;
    case (state)
      ST_IDLE:
      begin
        if (take)
        begin
          next_state = ST_SEND;
          next_rsp_addr = REQ_ADDR; // R14
          next_rsp_exc = (code != EXC_NONE);
          next_rsp_code = code; // R16
          next_rsp_crc_en = 1'b0;
          next_rsp_crc = CRC_INIT;
          if (code != EXC_NONE)
          begin
            next_rsp_func = REQ_FUNC | EXC_FLAG; // R15
            next_rsp_data = {8'h00, code}; // R16
            next_rsp_crc_en = RTU_MODE; // R18
            next_rsp_crc = exc_crc({SLAVE_ADDR, REQ_FUNC | EXC_FLAG, code}); // R18
          end
          else
          begin
            next_rsp_func = REQ_FUNC; // R14
            // write echoes its data; read returns the scaled value
            next_rsp_data = is_read ? rd_scaled[15:0] : REQ_DATA; // R4
            if (is_write && is_pw_addr)
              next_unlocked = 1'b1; // R9
            else if (is_write)
            begin
              // split the integer by the scale into whole and fraction
              next_wr_go = 1'b1; // R3
              next_wr_addr = REQ_ADDR;
              next_wr_whole = REQ_DATA / scale; // R3
              next_wr_frac = 10'(REQ_DATA % scale); // R3
            end
          end
        end
      end
      ST_SEND:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
    // a cleared password drops the lock state so a new one starts locked
    if (!pw_set)
      next_unlocked = 1'b0;
  end

  // ==========================================================================
  // registers
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state <= ST_IDLE;
      unlocked <= 1'b0;
      rsp_exc <= 1'b0;
      rsp_func <= 8'h00;
      rsp_addr <= 16'h0000;
      rsp_data <= 16'h0000;
      rsp_code <= EXC_NONE;
      rsp_crc_en <= 1'b0;
      rsp_crc <= CRC_INIT;
      wr_go <= 1'b0;
      wr_addr <= 16'h0000;
      wr_whole <= 16'h0000;
      wr_frac <= 10'h000;
    end
    else
    begin
      state <= next_state;
      unlocked <= next_unlocked;
      rsp_exc <= next_rsp_exc;
      rsp_func <= next_rsp_func;
      rsp_addr <= next_rsp_addr;
      rsp_data <= next_rsp_data;
      rsp_code <= next_rsp_code;
      rsp_crc_en <= next_rsp_crc_en;
      rsp_crc <= next_rsp_crc;
      wr_go <= next_wr_go;
      wr_addr <= next_wr_addr;
      wr_whole <= next_wr_whole;
      wr_frac <= next_wr_frac;
    end
  end

  // ==========================================================================
  // outputs
  assign REQ_READY = (state == ST_IDLE); // one request in flight at a time
  assign RSP_VALID = (state == ST_SEND);
  assign RSP_EXC = rsp_exc;
  assign RSP_FUNC = rsp_func;
  assign RSP_ADDR = rsp_addr;
  assign RSP_DATA = rsp_data;
  assign RSP_EXC_CODE = rsp_code;
  assign RSP_CRC_EN = rsp_crc_en;
  assign RSP_CRC = rsp_crc;
  assign PARAM_WR = wr_go;
  assign PARAM_WR_ADDR = wr_addr;
  assign PARAM_WR_WHOLE = wr_whole;
  assign PARAM_WR_FRAC = wr_frac;
  assign SYS_UNLOCKED = unlocked;

endmodule
`default_nettype wire

//--- tb/msr_checker_props.sv
// checker: reply timing, echo and exception coding of the responder
`timescale 1ns/10ps
`default_nettype none
module msr_checker
  import msr_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire logic [7:0] REQ_FUNC,
  input wire logic [15:0] REQ_ADDR,
  input wire logic REQ_LEN_OK,
  input wire logic REQ_CRC_OK,
  input wire logic RTU_MODE,
  input wire logic RSP_VALID,
  input wire logic RSP_EXC,
  input wire logic [7:0] RSP_FUNC,
  input wire logic [15:0] RSP_ADDR,
  input wire logic [15:0] RSP_DATA,
  input wire logic [7:0] RSP_EXC_CODE,
  input wire logic RSP_CRC_EN,
  input wire logic PARAM_WR
);
  // ==========================================================================
  // properties, all on the one clock
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  logic take;
  // a request counts once both sides agree on the edge
  assign take = REQ_VALID && REQ_READY;
  reply_after_take_a: assert property (take |=> RSP_VALID)
    else $error("no reply one cycle after take");
  reply_single_a: assert property (RSP_VALID |=> !RSP_VALID && REQ_READY)
    else $error("reply not a single pulse");
  norm_echo_a: assert property (RSP_VALID && !RSP_EXC |-> RSP_FUNC == $past(REQ_FUNC)
    && RSP_ADDR == $past(REQ_ADDR)) else $error("normal reply does not echo");
  exc_func_a: assert property (RSP_VALID && RSP_EXC
    |-> RSP_FUNC == ($past(REQ_FUNC) | EXC_FLAG))
    else $error("exception function code wrong");
  exc_byte_a: assert property (RSP_VALID && RSP_EXC |-> RSP_DATA == {8'h00, RSP_EXC_CODE})
    else $error("exception byte wrong");
  frame_err_a: assert property (take && !REQ_LEN_OK
    |=> RSP_EXC && RSP_EXC_CODE == EXC_FRAME)
    else $error("bad length not reported");
  bad_func_a: assert property (take && REQ_LEN_OK && REQ_CRC_OK && REQ_FUNC != FUNC_READ
    && REQ_FUNC != FUNC_WRITE |=> RSP_EXC_CODE == EXC_ILLEGAL_FUNC) else $error("bad function");
  crc_gate_a: assert property (RSP_VALID |-> RSP_CRC_EN == (RSP_EXC && $past(RTU_MODE)))
    else $error("crc enable wrong");
  store_ok_a: assert property (PARAM_WR
    |-> RSP_VALID && !RSP_EXC && $past(REQ_FUNC) == FUNC_WRITE)
    else $error("store without good write");
  cover property (RSP_VALID && RSP_EXC);
  cover property (PARAM_WR);
  cover property (RSP_VALID && !RSP_EXC && RSP_FUNC == FUNC_READ);
endmodule
bind msr_responder msr_checker ck_u (.MCLK(MCLK), .RST_N(RST_N), .REQ_VALID(REQ_VALID),
  .REQ_READY(REQ_READY), .REQ_FUNC(REQ_FUNC), .REQ_ADDR(REQ_ADDR), .REQ_LEN_OK(REQ_LEN_OK),
  .REQ_CRC_OK(REQ_CRC_OK), .RTU_MODE(RTU_MODE), .RSP_VALID(RSP_VALID), .RSP_EXC(RSP_EXC),
  .RSP_FUNC(RSP_FUNC), .RSP_ADDR(RSP_ADDR), .RSP_DATA(RSP_DATA), .RSP_EXC_CODE(RSP_EXC_CODE),
  .RSP_CRC_EN(RSP_CRC_EN), .PARAM_WR(PARAM_WR));
`default_nettype wire

//--- tb/msr_master.sv
// partner: upper computer model offering parsed requests
`timescale 1ns/10ps
`default_nettype none
module msr_master
(
  input wire logic MCLK,
  input wire logic REQ_READY,
  output var logic REQ_VALID,
  output var logic [7:0] REQ_FUNC,
  output var logic [15:0] REQ_ADDR,
  output var logic [15:0] REQ_DATA,
  output var logic REQ_LEN_OK,
  output var logic REQ_CRC_OK
);
  // ==========================================================================
  // idle fields carry junk, never the last request
  initial
  begin
    REQ_VALID = 1'b0;
    {REQ_FUNC, REQ_ADDR, REQ_DATA, REQ_LEN_OK, REQ_CRC_OK} = 42'h2AAAAAAAAAA;
  end
  // held from a falling edge until ready is seen at a taking edge
  task automatic issue(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
    input logic lo, input logic co, output bit ok);
    int n;
    // let an edge pass so back-to-back calls never retoggle valid in one step
    @(negedge MCLK);
    {REQ_FUNC, REQ_ADDR, REQ_DATA, REQ_LEN_OK, REQ_CRC_OK} = {f, a, d, lo, co};
    REQ_VALID = 1'b1;
    ok = 1'b0;
    for (n = 0; n < 16 && !ok; n++)
    begin
      ok = REQ_READY;
      @(negedge MCLK);
    end
    REQ_VALID = 1'b0;
    {REQ_FUNC, REQ_ADDR, REQ_DATA, REQ_LEN_OK, REQ_CRC_OK} = ~{f, a, d, lo, co};
  endtask
endmodule
`default_nettype wire

//--- tb/tb_modbus_scaled_param_exception_responder.sv
// testbench: scaling, echo and exception replies of the responder
`timescale 1ns/10ps
`default_nettype none
module tb_modbus_scaled_param_exception_responder
  import msr_pkg::*;
  ;
  // ==========================================================================
  // signals; context is driven on falling edges
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid, req_ready, len_ok, crc_ok, rsp_valid, rsp_exc, param_wr, unlocked;
  logic rsp_crc_en, rtu = 1'b1, run = 1'b1;
  logic [15:0] rsp_crc;
  // own station address; any value serves the crc check
  localparam logic [7:0] STATION = 8'h03;
  logic fault = 1'b0, span = 1'b1, ro = 1'b0, rl = 1'b0, cf = 1'b0;
  logic [1:0] dec = 2'h2;
  logic [7:0] func, rsp_func, exc_code;
  logic [15:0] addr, data, rsp_addr, rsp_data, wr_addr, wr_whole, pwd = 16'h0000;
  logic [15:0] rd_whole = 16'h0005;
  logic [9:0] rd_frac = 10'h003, wr_frac;
  int num_errors = 0;
  int samples_checked = 0;
  msr_master mst_u (.MCLK(mclk), .REQ_READY(req_ready), .REQ_VALID(req_valid),
    .REQ_FUNC(func), .REQ_ADDR(addr), .REQ_DATA(data), .REQ_LEN_OK(len_ok), .REQ_CRC_OK(crc_ok));
  msr_responder #(.MAX_READ_WORDS(16)) dut_u (.MCLK(mclk), .RST_N(rst_n), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_FUNC(func), .REQ_ADDR(addr), .REQ_DATA(data),
    .REQ_LEN_OK(len_ok), .REQ_CRC_OK(crc_ok), .RTU_MODE(rtu), .SLAVE_ADDR(STATION),
    .DRIVE_RUNNING(run), .DRIVE_FAULT(fault), .ADDR_SPAN_OK(span), .PARAM_READ_ONLY(ro),
    .PARAM_RUN_LOCKED(rl), .PARAM_CONFLICT(cf), .PARAM_DECIMALS(dec), .PARAM_MIN(16'h0000),
    .PARAM_MAX(16'h2710), .PARAM_RD_WHOLE(rd_whole), .PARAM_RD_FRAC(rd_frac),
    .USER_PASSWORD_SETTING(pwd), .RSP_VALID(rsp_valid), .RSP_EXC(rsp_exc), .RSP_FUNC(rsp_func),
    .RSP_ADDR(rsp_addr), .RSP_DATA(rsp_data), .RSP_EXC_CODE(exc_code), .RSP_CRC_EN(rsp_crc_en),
    .RSP_CRC(rsp_crc), .PARAM_WR(param_wr), .PARAM_WR_ADDR(wr_addr), .PARAM_WR_WHOLE(wr_whole),
    .PARAM_WR_FRAC(wr_frac), .SYS_UNLOCKED(unlocked));
  // ==========================================================================
  // shared checks and transfers

  // reference crc-16, bit-serial, each byte lsb first
  function automatic logic [15:0] ref_crc(input logic [23:0] msg);
    logic [15:0] r;
    logic fb;
    r = CRC_INIT;
    for (int k = 0; k < 24; k++)
    begin
      fb = r[0] ^ msg[16 - 8 * (k / 8) + (k % 8)];
      r = fb ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
  task automatic tally_and_finish();
    $display("mismatches %0d of %0d checks", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic c, input string m);
    samples_checked++;
    if (c !== 1'b1)
    begin
      num_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // returns in the reply cycle, so one-cycle pulses are still up
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
    input logic lo, input logic co);
    bit ok;
    mst_u.issue(f, a, d, lo, co, ok);
    // a request never taken is a mismatch, so a hang cannot pass
    if (!ok)
    begin
      num_errors++;
      $display("BAD %0t request never taken", $time);
      tally_and_finish();
    end
    else
      chk(rsp_valid === 1'b1, "no reply");
  endtask
  task automatic exp_norm(input logic [7:0] f, input logic [15:0] d);
    chk(rsp_exc === 1'b0 && exc_code === EXC_NONE, "unexpected exception");
    chk(rsp_func === f && rsp_addr === 16'h0001 && rsp_data === d, "echo wrong");
    chk(rsp_crc_en === 1'b0 && rsp_crc === CRC_INIT, "crc on normal reply");
  endtask
  task automatic exp_exc(input logic [7:0] f, input logic [7:0] c);
    logic [15:0] want;
    want = ref_crc({STATION, f | EXC_FLAG, c});
    chk(rsp_crc_en === rtu && rsp_crc === want, "exception crc wrong");
    chk(rsp_exc === 1'b1 && exc_code === c, "exception code wrong");
    chk(rsp_func === (f | 8'h80) && rsp_data === {8'h00, c}, "exception frame wrong");
    chk(param_wr === 1'b0, "store on exception");
  endtask
  // ==========================================================================
  // scenarios
  task automatic sc_write();
    logic [15:0] dv [3] = '{16'h2710, 16'h1394, 16'h0063};
    foreach (dv[i])
    begin
      xfer(FUNC_WRITE, 16'h0001, dv[i], 1'b1, 1'b1);
      exp_norm(FUNC_WRITE, dv[i]);
      chk(param_wr === 1'b1 && wr_addr === 16'h0001, "no store");
      chk(wr_whole === dv[i] / SCALE_100 && wr_frac === 10'(dv[i] % SCALE_100), "scale");
    end
  endtask
  task automatic sc_read();
    dec = 2'h1;
    xfer(FUNC_READ, 16'h0001, 16'h0010, 1'b1, 1'b1);
    exp_norm(FUNC_READ, 16'h0035);
    chk(param_wr === 1'b0, "store on read");
  endtask
  // rows: function, data, {len, crc, fault, span, ro, rl, conflict}, code
  task automatic sc_exc();
    logic [38:0] t [11] = '{{8'h03, 16'h1, 7'h28, 8'h06}, {8'h03, 16'h1, 7'h48, 8'h06},
      {8'h10, 16'h1, 7'h68, 8'h01}, {8'h03, 16'h1, 7'h78, 8'h01}, {8'h03, 16'h1, 7'h60, 8'h02},
      {8'h03, 16'h0, 7'h68, 8'h03}, {8'h03, 16'h11, 7'h68, 8'h03}, {8'h06, 16'h1, 7'h6C, 8'h07},
      {8'h06, 16'h1, 7'h6A, 8'h08}, {8'h06, 16'h2711, 7'h68, 8'h04}, {8'h06, 16'h1, 7'h69, 8'h04}};
    foreach (t[i])
    begin
      {fault, span, ro, rl, cf} = t[i][12:8];
      xfer(t[i][38:31], 16'h0001, t[i][30:15], t[i][14], t[i][13]);
      exp_exc(t[i][38:31], t[i][7:0]);
    end
    {fault, span, ro, rl, cf} = 5'h08;
  endtask
  // framing without crc, then a run-locked write while stopped
  task automatic sc_mode();
    rtu = 1'b0;
    xfer(FUNC_READ, 16'h0001, 16'h0001, 1'b1, 1'b0);
    exp_norm(FUNC_READ, 16'h0035);
    xfer(FUNC_WRITE, 16'h0001, 16'h2711, 1'b1, 1'b0);
    exp_exc(FUNC_WRITE, EXC_OP_FAIL);
    rtu = 1'b1;
    rl = 1'b1;
    run = 1'b0;
    xfer(FUNC_WRITE, 16'h0001, 16'h0032, 1'b1, 1'b1);
    exp_norm(FUNC_WRITE, 16'h0032);
    chk(param_wr === 1'b1 && wr_whole === 16'h0005 && wr_frac === 10'h000, "run lock");
    rl = 1'b0;
    run = 1'b1;
  endtask
  task automatic sc_lock();
    pwd = 16'h1234;
    xfer(FUNC_READ, 16'h0001, 16'h0001, 1'b1, 1'b1);
    exp_exc(FUNC_READ, EXC_SYS_LOCKED);
    xfer(FUNC_WRITE, PASSWORD_ADDR, 16'h1233, 1'b1, 1'b1);
    exp_exc(FUNC_WRITE, EXC_PASSWORD);
    xfer(FUNC_WRITE, PASSWORD_ADDR, 16'h1234, 1'b1, 1'b1);
    chk(rsp_exc === 1'b0 && param_wr === 1'b0, "password write");
    @(negedge mclk);
    chk(unlocked === 1'b1, "still locked");
    xfer(FUNC_READ, 16'h0001, 16'h0001, 1'b1, 1'b1);
    exp_norm(FUNC_READ, 16'h0035);
  endtask
  // ==========================================================================
  // clock, reset and main sequence
  initial
  begin
    forever #2.5 mclk = ~mclk;
  end
  initial
  begin
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    sc_write();
    sc_read();
    sc_exc();
    sc_mode();
    sc_lock();
    tally_and_finish();
  end
endmodule
`default_nettype wire
